// [arb_pkg.sv]
package arb_pkg;
  localparam int SAMPLE_W = 8;
  localparam int IDX_W = 17;
  localparam int CNT_W = 16;
  localparam int ACQ_W = 8;
  localparam int MEM_AW = 10;
  localparam int MEM_DEPTH = 1024;
  localparam int ACC_FRAC = 8;
  localparam int ACC_W = 16;
  localparam int STEP_W = 5;
  localparam int SPACE_W = 9;
  localparam int FIFO_DEPTH = 4;
  localparam logic [IDX_W-1:0] PEAK_SHORT_MAX_LEN = 17'h07530;
  localparam logic [IDX_W-1:0] PEAK_LONG_MIN_LEN = 17'h0C350;
  localparam logic [SPACE_W-1:0] PEAK_SHORT_PS = 9'h064;
  localparam logic [SPACE_W-1:0] PEAK_LONG_PS = 9'h190;
  localparam logic [STEP_W-1:0] INTERP_BASE_PTS = 5'h02;

  typedef enum logic [1:0] {
    ARB_SAMPLE,
    ARB_PEAK,
    ARB_ENVELOPE,
    ARB_AVERAGE
  } arb_mode_type;

  typedef struct packed {
    logic [IDX_W-1:0] index;
    logic [SAMPLE_W-1:0] value;
  } arb_point_type;

  localparam int POINT_W = IDX_W + SAMPLE_W;

  function automatic logic [STEP_W-1:0] arb_interp_pts(
    input logic [1:0] shift
  );
    arb_interp_pts = INTERP_BASE_PTS << shift;
  endfunction : arb_interp_pts
endpackage : arb_pkg

// [arb_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module arb_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic inValid, // Write request
  output logic inReady, // Space available
  input wire logic [WIDTH-1:0] inData, // Write data
  output logic outValid, // Data available
  input wire logic outReady, // Reader takes data
  output logic [WIDTH-1:0] outData // Head of queue
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] level;
  wire doWrite = inValid && inReady;
  wire doRead = outValid && outReady;

  assign inReady = level != (AW+1)'(DEPTH);
  assign outValid = level != '0;
  assign outData = store[rdPtr];

  always_ff @(posedge clk_sys) begin
    if (doWrite) begin
      store[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wrPtr <= '0;
      rdPtr <= '0;
      level <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      level <= level + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end
endmodule : arb_fifo
`default_nettype wire

// [arb_interp.sv]
`timescale 1ns/10ps
`default_nettype none
module arb_interp
  import arb_pkg::*;
(
  input wire logic [SAMPLE_W-1:0] prev2, // Sample before previous
  input wire logic [SAMPLE_W-1:0] prev, // Previous real sample
  input wire logic [SAMPLE_W-1:0] cur, // Newest real sample
  input wire logic [STEP_W-1:0] step, // Position 1..points
  input wire logic [1:0] shift, // Points per sample is 2 << shift
  input wire logic curveFit, // Curve fit instead of straight line
  output logic [SAMPLE_W-1:0] value // Interpolated point
);
  logic signed [9:0] slopeNew;
  logic signed [9:0] slopeOld;
  logic signed [19:0] linPart;
  logic signed [19:0] bendPart;
  logic signed [19:0] total;
  logic [STEP_W-1:0] nPts;
  logic [2:0] div1;
  logic [3:0] div2;
  logic [STEP_W-1:0] remain;

  assign nPts = arb_interp_pts(shift);
  assign div1 = 3'(shift) + 3'h1;
  assign div2 = 4'(div1) + 4'(div1) + 4'h1;
  assign remain = nPts - step;
  assign slopeNew = 10'(signed'({2'b00, cur})) - 10'(signed'({2'b00, prev}));
  assign slopeOld = 10'(signed'({2'b00, prev})) - 10'(signed'({2'b00, prev2}));
  // Straight line at the point's time position
  assign linPart = 20'(signed'({12'h000, prev})) +
                   ((20'(slopeNew) * 20'(signed'({15'h0000, step}))) >>> div1);
  // Bend follows the change of slope across three samples
  assign bendPart = (20'(slopeNew - slopeOld) *
                     20'(signed'({15'h0000, step})) *
                     20'(signed'({15'h0000, remain}))) >>> div2;
  assign total = curveFit ? linPart + bendPart : linPart;
  // Curve overshoot is clipped to the sample range
  assign value = (total < 0) ? '0 :
                 (total > 20'sh000FF) ? {SAMPLE_W{1'b1}} : total[SAMPLE_W-1:0];
endmodule : arb_interp
`default_nettype wire

// [arb_record_builder.sv]
`timescale 1ns/10ps
`default_nettype none
module arb_record_builder
  import arb_pkg::*;
(
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic startSeq, // Start a new acquisition sequence
  input wire logic [1:0] modeSel, // Requested acquisition mode
  input wire logic [ACQ_W-1:0] acqCount, // Records to envelope or average
  input wire logic [CNT_W-1:0] samplesPerPoint, // Samples per interval
  input wire logic [IDX_W-1:0] recordLength, // Record points
  input wire logic interpNeeded, // Time base too fast for real fill
  input wire logic curveFit, // Curve-fit interpolation selected
  input wire logic [1:0] interpShift, // Points per real sample: 2 << n
  input wire logic trigger, // Trigger pin, asynchronous
  input wire logic sampleValid, // Digitizer sample present
  input wire logic [SAMPLE_W-1:0] sampleData, // Digitizer sample
  output logic sampleReady, // Sample taken this cycle
  output logic pointValid, // Record point available
  input wire logic pointReady, // Record memory takes point
  output arb_point_type pointData, // Record point and its index
  output arb_mode_type modeReport, // Mode as selected
  output arb_mode_type effMode, // Mode as processed
  output logic [SPACE_W-1:0] peakSpacingPs, // Peak capture sample spacing
  output logic busy, // Sequence in progress
  output logic seqDone // Sequence complete, level
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARMED,
    ST_ACQ,
    ST_INTERP,
    ST_DONE
  } arb_state_type;

  arb_state_type state;
  arb_mode_type curMode;
  logic [ACQ_W-1:0] acqsDone;
  logic [IDX_W-1:0] pointIdx;
  logic [CNT_W-1:0] sampCnt;
  logic [SAMPLE_W-1:0] firstVal;
  logic [SAMPLE_W-1:0] maxVal;
  logic [SAMPLE_W-1:0] minVal;
  logic [SAMPLE_W-1:0] prev2;
  logic [SAMPLE_W-1:0] prev;
  logic [SAMPLE_W-1:0] cur;
  logic primed;
  logic [STEP_W-1:0] step;
  logic trigMeta;
  logic trigSync;
  logic trigLast;
  logic [ACC_W-1:0] store [MEM_DEPTH];

  logic fifoReady;
  logic pushValid;
  arb_point_type pushData;
  logic [SAMPLE_W-1:0] interpVal;

  function automatic logic [3:0] arb_log2(input logic [ACQ_W-1:0] n);
    logic [3:0] r;
    r = '0;
    for (int i = 0; i < ACQ_W; i++) begin
      if (n[i]) begin
        r = 4'(i);
      end
    end
    arb_log2 = r;
  endfunction : arb_log2

  // Trigger pin crosses into the clock domain first
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      trigMeta <= 1'b0;
      trigSync <= 1'b0;
      trigLast <= 1'b0;
    end else begin
      trigMeta <= trigger;
      trigSync <= trigMeta;
      trigLast <= trigSync;
    end
  end

  wire trigEdge = trigSync && !trigLast;
  wire modeChange = modeSel != curMode;
  wire multiAcq = (curMode == ARB_ENVELOPE) || (curMode == ARB_AVERAGE);
  wire firstAcq = acqsDone == '0;
  wire [STEP_W-1:0] nPts = arb_interp_pts(interpShift);

  // Interpolated data cannot carry peaks, so peak runs as sample
  assign modeReport = curMode;
  assign effMode = (curMode == ARB_PEAK && interpNeeded) ? ARB_SAMPLE : curMode;
  assign peakSpacingPs = (recordLength <= PEAK_SHORT_MAX_LEN) ? PEAK_SHORT_PS :
                         PEAK_LONG_PS;
  assign busy = (state == ST_ARMED) || (state == ST_ACQ) ||
                (state == ST_INTERP);
  assign seqDone = state == ST_DONE;

  // Before the trigger stale samples are drained and thrown away
  assign sampleReady = !modeChange && ((state == ST_ARMED) ||
                       (state == ST_ACQ && fifoReady));
  wire sampAcc = sampleValid && sampleReady && state == ST_ACQ;
  wire realPath = !interpNeeded;
  wire intervalFirst = sampCnt == '0;
  wire intervalLast = sampCnt >= samplesPerPoint - 1'b1;

  // Reductions including the sample arriving this cycle
  wire [SAMPLE_W-1:0] redFirst = intervalFirst ? sampleData : firstVal;
  wire [SAMPLE_W-1:0] redMax = (intervalFirst || sampleData > maxVal) ?
                               sampleData : maxVal;
  wire [SAMPLE_W-1:0] redMin = (intervalFirst || sampleData < minVal) ?
                               sampleData : minVal;
  wire takeMax = !pointIdx[0];
  wire extremeMode = (effMode == ARB_PEAK) || (effMode == ARB_ENVELOPE);
  wire [SAMPLE_W-1:0] realPoint = !extremeMode ? redFirst :
                                  takeMax ? redMax : redMin;

  wire realStrobe = sampAcc && realPath && intervalLast;
  wire interpStrobe = state == ST_INTERP && fifoReady && !modeChange;
  wire strobe = realStrobe || interpStrobe;
  wire [SAMPLE_W-1:0] rawPoint = realPath ? realPoint : interpVal;
  wire lastPoint = pointIdx == recordLength - 1'b1;

  // Per-point history, indexed modulo the memory depth
  wire [MEM_AW-1:0] memAddr = pointIdx[MEM_AW-1:0];
  wire [ACC_W-1:0] memWord = store[memAddr];
  wire [SAMPLE_W-1:0] memVal = memWord[ACC_W-1:ACC_FRAC];
  wire [ACC_W-1:0] rawWord = {rawPoint, {ACC_FRAC{1'b0}}};
  wire [SAMPLE_W-1:0] envPoint = takeMax ?
                                 ((rawPoint > memVal) ? rawPoint : memVal) :
                                 ((rawPoint < memVal) ? rawPoint : memVal);
  // Running mean is exact only at power-of-two acquisition counts
  wire [3:0] avgWeight = arb_log2(acqsDone + 1'b1);
  wire signed [ACC_W+1:0] avgDelta = (ACC_W+2)'(signed'({2'b00, rawWord})) -
                                     (ACC_W+2)'(signed'({2'b00, memWord}));
  wire signed [ACC_W+1:0] avgStep = avgDelta >>> avgWeight;
  wire [ACC_W+1:0] avgSum = (ACC_W+2)'(memWord) + avgStep;
  wire [ACC_W-1:0] avgWord = avgSum[ACC_W-1:0];

  logic [ACC_W-1:0] next_word;
  always_comb begin
    next_word = rawWord;
    if (!firstAcq && effMode == ARB_ENVELOPE) begin
      next_word = {envPoint, {ACC_FRAC{1'b0}}};
    end else if (!firstAcq && effMode == ARB_AVERAGE) begin
      next_word = avgWord;
    end
  end

  assign pushValid = strobe;
  assign pushData.index = pointIdx;
  assign pushData.value = next_word[ACC_W-1:ACC_FRAC];

  always_ff @(posedge clk_sys) begin
    if (strobe && multiAcq) begin
      store[memAddr] <= next_word;
    end
  end

  arb_interp u_interp (
    .prev2(prev2),
    .prev(prev),
    .cur(cur),
    .step(step),
    .shift(interpShift),
    .curveFit(curveFit),
    .value(interpVal)
  );

  arb_fifo #(
    .WIDTH(POINT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .inValid(pushValid),
    .inReady(fifoReady),
    .inData(pushData),
    .outValid(pointValid),
    .outReady(pointReady),
    .outData(pointData)
  );

  // Interval reduction registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sampCnt <= '0;
      firstVal <= '0;
      maxVal <= '0;
      minVal <= '0;
    end else if (state != ST_ACQ) begin
      sampCnt <= '0;
    end else if (sampAcc && realPath) begin
      sampCnt <= intervalLast ? '0 : sampCnt + 1'b1;
      firstVal <= redFirst;
      maxVal <= redMax;
      minVal <= redMin;
    end
  end

  // Real-sample history for interpolation
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      prev2 <= '0;
      prev <= '0;
      cur <= '0;
      primed <= 1'b0;
    end else if (state != ST_ACQ && state != ST_INTERP) begin
      primed <= 1'b0;
    end else if (sampAcc && !realPath) begin
      prev2 <= primed ? prev : sampleData;
      prev <= primed ? cur : sampleData;
      cur <= sampleData;
      primed <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      curMode <= ARB_SAMPLE;
      acqsDone <= '0;
      pointIdx <= '0;
      step <= '0;
    end else if (modeChange) begin
      state <= ST_IDLE;
      curMode <= arb_mode_type'(modeSel);
      acqsDone <= '0;
      pointIdx <= '0;
    end else begin
      case (state)
        ST_IDLE, ST_DONE: begin
          if (startSeq) begin
            state <= ST_ARMED;
            acqsDone <= '0;
            pointIdx <= '0;
          end
        end
        ST_ARMED: begin
          if (trigEdge) begin
            state <= ST_ACQ;
            pointIdx <= '0;
          end
        end
        ST_ACQ: begin
          if (sampAcc && !realPath && primed) begin
            state <= ST_INTERP;
            step <= {{(STEP_W-1){1'b0}}, 1'b1};
          end
        end
        ST_INTERP: begin
          if (interpStrobe) begin
            step <= step + 1'b1;
            if (step >= nPts) begin
              state <= ST_ACQ;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      if (strobe) begin
        pointIdx <= lastPoint ? '0 : pointIdx + 1'b1;
        if (lastPoint) begin
          acqsDone <= acqsDone + 1'b1;
          // Count of records comes from the controller
          state <= (multiAcq && acqsDone + 1'b1 < acqCount) ?
                   ST_ARMED : ST_DONE;
        end
      end
    end
  end

  property p_no_take_idle;
    @(posedge clk_sys) disable iff (!rst_b)
    (state == ST_IDLE || state == ST_DONE) |-> !sampleReady;
  endproperty
  a_no_take_idle: assert property (p_no_take_idle)
    else $error("sample taken outside an acquisition");

  property p_reset_mode;
    @(posedge clk_sys)
    (!rst_b ##1 rst_b) |-> (modeReport == ARB_SAMPLE || $past(modeSel) != 2'h0);
  endproperty
  a_reset_mode: assert property (p_reset_mode)
    else $error("mode not sample after reset");

  property p_sample_first;
    @(posedge clk_sys) disable iff (!rst_b)
    (realStrobe && effMode == ARB_SAMPLE && !intervalFirst)
      |-> pushData.value == firstVal;
  endproperty
  a_sample_first: assert property (p_sample_first)
    else $error("sample mode point is not the first sample");

  property p_peak_alt;
    @(posedge clk_sys) disable iff (!rst_b)
    (realStrobe && effMode == ARB_PEAK)
      |-> (pointIdx[0] ? pushData.value <= redFirst
                       : pushData.value >= redFirst);
  endproperty
  a_peak_alt: assert property (p_peak_alt)
    else $error("peak point not max then min");

  property p_peak_interp;
    @(posedge clk_sys) disable iff (!rst_b)
    (modeReport == ARB_PEAK && interpNeeded) |-> effMode == ARB_SAMPLE
      ##1 (modeReport == ARB_PEAK || $past(modeChange));
  endproperty
  a_peak_interp: assert property (p_peak_interp)
    else $error("peak capture not demoted or report changed");

  property p_spacing;
    @(posedge clk_sys) disable iff (!rst_b)
    (recordLength >= PEAK_LONG_MIN_LEN) |-> peakSpacingPs == PEAK_LONG_PS;
  endproperty
  a_spacing: assert property (p_spacing)
    else $error("long record peak spacing wrong");

  property p_env_extreme;
    @(posedge clk_sys) disable iff (!rst_b)
    (strobe && effMode == ARB_ENVELOPE && !firstAcq)
      |-> (takeMax ? pushData.value >= memVal : pushData.value <= memVal);
  endproperty
  a_env_extreme: assert property (p_env_extreme)
    else $error("envelope lost a stored extreme");

  property p_interp_end;
    @(posedge clk_sys) disable iff (!rst_b)
    (interpStrobe && step == nPts && !curveFit && effMode == ARB_SAMPLE)
      |-> pushData.value == cur;
  endproperty
  a_interp_end: assert property (p_interp_end)
    else $error("line does not reach the real sample");

  property p_clear_start;
    @(posedge clk_sys) disable iff (!rst_b)
    (state == ST_IDLE && startSeq && !modeChange)
      |=> (acqsDone == '0 && state == ST_ARMED);
  endproperty
  a_clear_start: assert property (p_clear_start)
    else $error("history not cleared at sequence start");
endmodule : arb_record_builder
`default_nettype wire

// [arb_stream_partner.sv]
`timescale 1ns/10ps
`default_nettype none
module arb_stream_partner
  import arb_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic stall, // Record memory holds off
  input wire logic slow, // Take a point every other cycle
  output logic sampleValid, // Sample present
  output logic [SAMPLE_W-1:0] sampleData, // Sample value
  input wire logic sampleReady, // Builder takes sample
  output logic pointReady // Memory takes point
);
  initial begin
    sampleValid = 1'b0;
    sampleData = 8'h5A;
    pointReady = 1'b0;
  end

  always @(posedge clk_sys) begin
    pointReady <= #1 !stall && (!slow || !pointReady);
  end

  // Idle data is inverted so a stale value never looks like a fresh one
  task automatic send(input logic [SAMPLE_W-1:0] v, input logic last);
    logic ok;
    sampleValid = 1'b1;
    sampleData = v;
    do begin
      @(negedge clk_sys) ok = sampleReady;
      @(posedge clk_sys);
    end while (ok !== 1'b1);
    #1;
    if (last) begin
      sampleValid = 1'b0;
      sampleData = ~v;
    end
  endtask : send
endmodule : arb_stream_partner
`default_nettype wire

// [test_arb_record_builder.sv]
`timescale 1ns/10ps
`default_nettype none
module test_arb_record_builder
  import arb_pkg::*;
;
  logic clk_sys = 0, rst_b = 0, startSeq = 0, trigger = 0, stall = 0;
  logic slow = 0, interpNeeded = 0, curveFit = 0;
  logic [1:0] modeSel = 0, interpShift = 0;
  logic [ACQ_W-1:0] acqCount = 1;
  logic [CNT_W-1:0] samplesPerPoint = 1;
  logic [IDX_W-1:0] recordLength = 17'h07530;
  logic sampleValid, sampleReady, pointValid, pointReady, busy, seqDone;
  logic [SAMPLE_W-1:0] sampleData, v;
  arb_point_type pointData, want;
  arb_mode_type modeReport, effMode;
  logic [SPACE_W-1:0] peakSpacingPs;
  logic [31:0] seed = 32'h9DEFFD83;
  logic [7:0] d[$], e[$], env[4];
  arb_point_type expq[$];
  int n_fail = 0, checked = 0, cycles = 0, n, t;

  arb_record_builder dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .startSeq(startSeq), .modeSel(modeSel), .acqCount(acqCount),
    .samplesPerPoint(samplesPerPoint), .recordLength(recordLength),
    .interpNeeded(interpNeeded), .curveFit(curveFit),
    .interpShift(interpShift), .trigger(trigger),
    .sampleValid(sampleValid), .sampleData(sampleData),
    .sampleReady(sampleReady), .pointValid(pointValid),
    .pointReady(pointReady), .pointData(pointData),
    .modeReport(modeReport), .effMode(effMode),
    .peakSpacingPs(peakSpacingPs), .busy(busy), .seqDone(seqDone));

  arb_stream_partner partner (.clk_sys(clk_sys), .stall(stall),
    .slow(slow), .sampleValid(sampleValid), .sampleData(sampleData),
    .sampleReady(sampleReady), .pointReady(pointReady));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Interval reduction: first sample, or max on even and min on odd points
  function automatic logic [7:0] red(input logic [7:0] q[$], input int i,
    input int spp, input int pk);
    logic [7:0] r;
    r = q[i * spp];
    for (int j = 1; j < spp; j++) begin
      if (pk != 0 && ((i % 2 == 0) == (q[i * spp + j] > r)))
        r = q[i * spp + j];
    end
    return r;
  endfunction : red

  task automatic rnd(output logic [7:0] q[$], input int cnt);
    q = {};
    repeat (cnt) begin
      seed = lfsr(seed);
      q.push_back(seed[7:0]);
    end
  endtask : rnd

  task automatic report_and_stop;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic cmpVal(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmpVal

  task automatic cmpPt(input arb_point_type got, input arb_point_type exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmpPt

  task automatic setup(input logic [1:0] m, input logic [15:0] spp,
    input logic [16:0] rl, input logic [7:0] acq, input logic ip);
    modeSel = m;
    samplesPerPoint = spp;
    recordLength = rl;
    acqCount = acq;
    interpNeeded = ip;
    repeat (2) @(posedge clk_sys);
    #1 startSeq = 1'b1;
    @(posedge clk_sys);
    #1 startSeq = 1'b0;
  endtask : setup

  // Samples offered while armed must be dropped before the trigger
  task automatic acquire(input logic [7:0] q[$]);
    // A clock edge between records keeps valid from two writes in one step
    @(posedge clk_sys);
    #1;
    repeat (2) partner.send(8'hE7, 1'b0);
    partner.send(8'h18, 1'b1);
    trigger = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 trigger = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    foreach (q[i]) partner.send(q[i], i == q.size() - 1);
  endtask : acquire

  task automatic finishSeq;
    int k = 0;
    while ((seqDone !== 1'b1 || expq.size() != 0) && k < 500) begin
      @(posedge clk_sys);
      k++;
    end
    #1;
    cmpVal(seqDone, 16'h0001);
    cmpVal(expq.size(), 16'h0000);
  endtask : finishSeq

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end else if (rst_b === 1'b1 && pointValid === 1'b1 &&
                 pointReady === 1'b1) begin
      want = (expq.size() != 0) ? expq.pop_front() : 'x;
      cmpPt(pointData, want);
    end
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    cmpVal(modeReport, ARB_SAMPLE);
    cmpVal({busy, pointValid, seqDone}, 16'h0000);
    cmpVal(peakSpacingPs, 16'h0064);
    recordLength = 17'h0C350;
    #1 cmpVal(peakSpacingPs, 16'h0190);
    rnd(d, 12);
    for (int i = 0; i < 6; i++)
      expq.push_back({IDX_W'(i), red(d, i, 2, 0)});
    stall = 1'b1;
    setup(ARB_SAMPLE, 2, 6, 1, 0);
    fork
      acquire(d);
    join_none
    repeat (60) @(posedge clk_sys);
    #1 cmpVal({busy, pointValid, sampleReady}, 16'h0006);
    stall = 1'b0;
    wait fork;
    finishSeq();
    rnd(d, 12);
    for (int i = 0; i < 4; i++)
      expq.push_back({IDX_W'(i), red(d, i, 3, 1)});
    setup(ARB_PEAK, 3, 4, 1, 0);
    cmpVal({modeReport, effMode}, {ARB_PEAK, ARB_PEAK});
    acquire(d);
    finishSeq();
    slow = 1'b1;
    for (int r = 0; r < 2; r++) begin
      rnd(d, 8);
      rnd(e, 8);
      for (int i = 0; i < 4; i++) begin
        env[i] = red(d, i, 2, 1);
        expq.push_back({IDX_W'(i), env[i]});
      end
      for (int i = 0; i < 4; i++) begin
        v = red(e, i, 2, 1);
        if ((i % 2 == 0) == (v > env[i]))
          env[i] = v;
        expq.push_back({IDX_W'(i), env[i]});
      end
      setup(ARB_ENVELOPE, 2, 4, 2, 0);
      acquire(d);
      acquire(e);
      finishSeq();
    end
    rnd(d, 8);
    rnd(e, 8);
    foreach (e[j]) e[j][0] = d[j][0];
    for (int i = 0; i < 4; i++)
      expq.push_back({IDX_W'(i), d[2 * i]});
    for (int i = 0; i < 4; i++)
      expq.push_back({IDX_W'(i),
        8'((9'(d[2 * i]) + 9'(e[2 * i])) >> 1)});
    setup(ARB_AVERAGE, 2, 4, 2, 0);
    acquire(d);
    acquire(e);
    finishSeq();
    // Sample values are multiples of the step so the line part is exact;
    // the second half repeats every shift with the bend term of the curve
    for (int it = 0; it < 8; it++) begin
      n = 2 << (it % 4);
      interpShift = 2'(it % 4);
      curveFit = it >= 4;
      rnd(d, 3);
      foreach (d[j]) d[j] = d[j] & ~8'(n - 1);
      for (int j = 1; j < 3; j++) begin
        for (int k = 1; k <= n; k++) begin
          t = int'(d[j - 1]) + (int'(d[j]) - int'(d[j - 1])) * k / n;
          if (curveFit)
            t += ((int'(d[j]) - 2 * int'(d[j - 1]) + int'(d[0])) * k
              * (n - k)) >>> (2 * (it % 4) + 3);
          t = (t < 0) ? 0 : (t > 255) ? 255 : t;
          expq.push_back({IDX_W'((j - 1) * n + k - 1), 8'(t)});
        end
      end
      setup(ARB_PEAK, 1, IDX_W'(2 * n), 1, 1);
      cmpVal({modeReport, effMode}, {ARB_PEAK, ARB_SAMPLE});
      acquire(d);
      finishSeq();
    end
    report_and_stop();
  end
endmodule : test_arb_record_builder
`default_nettype wire
